// ### ptc_pulse_timer_counters.sv
// Purpose: Retriggerable pulse timer, up counter and down counter on one logic tick
// Assumes: Inputs synchronous to ref_clk; they are sampled once per tick
// Notes: All outputs registered; counts visible for observation
//   Inputs are looked at only on the tick clock, so pulses shorter than a tick are lost unless high on that clock
//   A zero preset duration never raises the pulse output
//   Presets are levels; change them only while the primitives are idle or in reset
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_pulse_timer_counters #(
  parameter int TICK_CYCLES = `PTC_TICK_CYCLES, // Clocks per logic tick
  parameter int COUNT_W = `PTC_COUNT_W, // Counter width
  parameter int TIME_W = `PTC_TIME_W // Duration width
) (
  input wire logic ref_clk, // System clock, 25 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire ptc_pkg::ptc_inputs_t sheetIn, // Input bits from sheet
  input wire ptc_pkg::ptc_time_t presetDuration, // Pulse length in ticks
  input wire ptc_pkg::ptc_count_t upPreset, // Up counter preset value
  input wire ptc_pkg::ptc_count_t downPreset, // Down counter preset value
  output logic tick, // One-clock logic tick strobe
  output logic pulseOut, // Retriggerable pulse output
  output logic upOut, // Up counter output
  output logic downOut, // Down counter output
  output ptc_pkg::ptc_count_t upCount, // Up running count
  output ptc_pkg::ptc_count_t downCount // Down running count
);
  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int IN_W = $bits(ptc_pkg::ptc_inputs_t);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Divider must count at least one clock per tick
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // Count width is fixed by the shared count type
  if (COUNT_W != `PTC_COUNT_W) begin : g_bad_count_w
    $error("COUNT_W must match the shared count type");
  end

  // Duration width is fixed by the shared duration type
  if (TIME_W != `PTC_TIME_W) begin : g_bad_time_w
    $error("TIME_W must match the shared duration type");
  end

  // One-bit rising edge: high now, low on the previous tick
  function automatic logic rise_of(
    input logic cur,
    input logic last
  );
    return cur & ~last;
  endfunction

  // Timer end test: true when one more tick reaches the preset
  function automatic logic at_preset(
    input ptc_pkg::ptc_time_t spent,
    input ptc_pkg::ptc_time_t limit
  );
    return ptc_pkg::ptc_time_t'(spent + 1'b1) >= limit;
  endfunction

  logic [TICK_W-1:0] tickCnt;
  ptc_pkg::ptc_inputs_t prevIn;
  ptc_pkg::ptc_inputs_t riseNow;
  ptc_pkg::ptc_time_t elapsed;
  ptc_pkg::ptc_time_t next_elapsed;
  ptc_pkg::ptc_pulse_state_t pulseState;
  ptc_pkg::ptc_pulse_state_t next_pulseState;
  ptc_pkg::ptc_cnt_state_t upState;
  ptc_pkg::ptc_cnt_state_t downState;
  wire logic tickNow = (tickCnt == TICK_LAST);
  wire logic timeUp;
  wire logic zeroLen;
  wire logic [IN_W-1:0] nowBits;
  wire logic [IN_W-1:0] lastBits;
  wire logic [IN_W-1:0] riseBits;
  wire logic [TICK_W-1:0] next_tickCnt;
  wire logic pulseRise;
  wire logic upRise;
  wire logic clearRise;
  wire logic downRise;
  wire logic loadRise;

  // Divider wraps after the last clock of a tick
  assign next_tickCnt = tickNow ? '0 : TICK_W'(tickCnt + 1'b1);

  // Divider count register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // Tick strobe, one clock, lines up with updated outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= tickNow;
    end
  end

  // Flat views of this tick's and last tick's input levels
  assign nowBits = sheetIn;
  assign lastBits = prevIn;

  // Edge strobe per input, valid only on a tick
  for (genvar b = 0; b < IN_W; b++) begin : g_edge
    assign riseBits[b] = tickNow & rise_of(nowBits[b], lastBits[b]); // R16
  end

  // Back into named fields
  assign riseNow = riseBits;

  // Named strobes for each primitive
  assign pulseRise = riseNow.pulseIn;
  assign upRise = riseNow.countUpInput;
  assign clearRise = riseNow.upClear;
  assign downRise = riseNow.countDownInput;
  assign loadRise = riseNow.loadInput;

  // Previous tick's inputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevIn <= '0; // R17
    end else if (tickNow) begin
      prevIn <= sheetIn; // R16
    end
  end

  // Pulse end and zero-length tests
  assign timeUp = at_preset(elapsed, presetDuration); // R15
  assign zeroLen = (presetDuration == '0);

  // Pulse timer: restart on every edge, end after preset ticks
  always_comb begin
    next_pulseState = pulseState;
    next_elapsed = elapsed;
    if (pulseRise) begin
      next_pulseState = zeroLen ? ptc_pkg::PTC_IDLE : ptc_pkg::PTC_HIGH; // R1
      next_elapsed = '0; // R2
    end else if (tickNow) begin
      unique case (pulseState)
        ptc_pkg::PTC_IDLE: begin
          next_elapsed = '0;
        end
        ptc_pkg::PTC_HIGH: begin
          if (timeUp) begin
            next_pulseState = ptc_pkg::PTC_IDLE; // R1 R15
            next_elapsed = '0;
          end else begin
            next_elapsed = ptc_pkg::ptc_time_t'(elapsed + 1'b1); // R15
          end
        end
      endcase
    end
  end

  // Pulse timer state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulseState <= ptc_pkg::PTC_IDLE; // R17
    end else begin
      pulseState <= next_pulseState;
    end
  end

  // Elapsed ticks since the last accepted edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      elapsed <= '0; // R17
    end else begin
      elapsed <= next_elapsed;
    end
  end

  // Pulse output, registered from the next state so it leaves no gap
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulseOut <= 1'b0; // R17
    end else begin
      pulseOut <= (next_pulseState == ptc_pkg::PTC_HIGH); // R1 R2
    end
  end

  // Up counter
  ptc_up_counter upCounter (
    .ref_clk(ref_clk),
    .rst(rst),
    .upEdge(upRise),
    .clearEdge(clearRise),
    .presetValue(upPreset),
    .state(upState)
  );

  // Down counter
  ptc_down_counter downCounter (
    .ref_clk(ref_clk),
    .rst(rst),
    .downEdge(downRise),
    .loadEdge(loadRise),
    .presetValue(downPreset),
    .state(downState)
  );

  // Counter outputs straight from child flip-flops
  assign upOut = upState.out;
  assign upCount = upState.runningCount;
  assign downOut = downState.out;
  assign downCount = downState.runningCount;
endmodule

// ### ptc_cfg.svh
// Purpose: Constants for the tick-driven pulse timer and counter primitives
// Assumes: One ref_clk at 25 MHz, one logic tick every TICK_CYCLES clocks
// Notes: Counts and timing figures only; types live in ptc_pkg
// Functional notes
// R1 - Rising input edge drives pulse output high for the preset duration, then low.
// R2 - New rising edge while pulse output high restarts the full preset duration.
// R3 - Up counter adds one on each rising edge of its count-up input.
// R4 - Up counter stops at the preset value; further count-up edges ignored.
// R5 - Up counter output high when running count is at or above preset.
// R6 - Rising edge on up counter clear input sets running count to zero.
// R7 - Up counter clear wins over count-up in the same tick.
// R8 - Up counter output stays high at preset until a clear edge.
// R9 - Rising edge on down counter load input copies preset into running count.
// R10 - Down counter load wins over count-down in the same tick.
// R11 - Down counter subtracts one on each rising edge of count-down input.
// R12 - Down counter never goes below zero; count-down at zero ignored.
// R13 - Down counter output high when running count is zero.
// R14 - Down counter output stays high at zero until a load edge.
// R15 - Preset durations are whole multiples of the periodic logic tick.
// R16 - Rising edges found by comparing this tick's input with the previous tick's.
// R17 - Reset clears all counts and timer states; outputs follow cleared state (up counter output is held low in reset, even with a zero preset).
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_CLK_HZ 25000000
`define PTC_TICK_US 1000
`define PTC_TICK_CYCLES ((`PTC_CLK_HZ / 1000000) * `PTC_TICK_US)
`define PTC_COUNT_W 16
`define PTC_TIME_W 16
`define PTC_RST_COUNT 16'h0000
`endif

// ### ptc_pkg.sv
// Purpose: Types shared by the pulse timer and counter primitives
// Assumes: Widths come from ptc_cfg.svh
// Notes: Each counter result travels as a packed struct
`include "ptc_cfg.svh"
package ptc_pkg;
  typedef logic [`PTC_COUNT_W-1:0] ptc_count_t;
  typedef logic [`PTC_TIME_W-1:0] ptc_time_t;
  // Input strobes seen on one tick
  typedef struct packed {
    logic pulseIn;
    logic countUpInput;
    logic upClear;
    logic countDownInput;
    logic loadInput;
  } ptc_inputs_t;
  // Counter result
  typedef struct packed {
    ptc_count_t runningCount;
    logic out;
  } ptc_cnt_state_t;
  // Pulse timer states, Gray along idle -> high
  typedef enum logic [0:0] {
    PTC_IDLE = 1'b0,
    PTC_HIGH = 1'b1
  } ptc_pulse_state_t;
endpackage

// ### ptc_up_counter.sv
// Purpose: Saturating up counter with clear input
// Assumes: Edge strobes are one clock wide, on the tick clock, provided by the parent
// Notes: Clear dominates counting
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_up_counter (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic upEdge, // Rising edge on count-up input
  input wire logic clearEdge, // Rising edge on clear input
  input wire ptc_pkg::ptc_count_t presetValue, // Preset value
  output ptc_pkg::ptc_cnt_state_t state // Running count and output
);
  ptc_pkg::ptc_count_t next_count;
  wire logic below = state.runningCount < presetValue;
  // Clear first, then count only below preset
  assign next_count = clearEdge ? `PTC_RST_COUNT : // R6 R7
    (upEdge && below) ? ptc_pkg::ptc_count_t'(state.runningCount + 1'b1) : // R3 R4
    state.runningCount;
  // Count and output registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state.runningCount <= `PTC_RST_COUNT; // R17
      state.out <= 1'b0;
    end else begin
      state.runningCount <= next_count;
      state.out <= (next_count >= presetValue); // R5 R8
    end
  end
endmodule

// ### ptc_down_counter.sv
// Purpose: Down counter with load input, floored at zero
// Assumes: Edge strobes are one clock wide, on the tick clock, provided by the parent
// Notes: Load dominates counting
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_down_counter (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic downEdge, // Rising edge on count-down input
  input wire logic loadEdge, // Rising edge on load input
  input wire ptc_pkg::ptc_count_t presetValue, // Preset value
  output ptc_pkg::ptc_cnt_state_t state // Running count and output
);
  ptc_pkg::ptc_count_t next_count;
  wire logic nonZero = state.runningCount != `PTC_RST_COUNT;
  // Load first, then count only above zero
  assign next_count = loadEdge ? presetValue : // R9 R10
    (downEdge && nonZero) ? ptc_pkg::ptc_count_t'(state.runningCount - 1'b1) : // R11 R12
    state.runningCount;
  // Count and output registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state.runningCount <= `PTC_RST_COUNT; // R17
      state.out <= 1'b1;
    end else begin
      state.runningCount <= next_count;
      state.out <= (next_count == `PTC_RST_COUNT); // R13 R14
    end
  end
endmodule

// ### ptc_properties.sv
// Purpose: Port checks for pulse timer and counters
// Assumes: Presets held steady while running
// Notes: Bound into the top module
`timescale 1ns/1ps
module ptc_checker #(
  parameter int TICK_CYCLES = 4 // Clocks per tick
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire ptc_pkg::ptc_inputs_t sheetIn, // Sheet bits
  input wire ptc_pkg::ptc_time_t presetDuration, // Pulse length
  input wire ptc_pkg::ptc_count_t upPreset, // Up preset
  input wire ptc_pkg::ptc_count_t downPreset, // Down preset
  input wire logic tick, // Tick strobe
  input wire logic pulseOut, // Pulse out
  input wire logic upOut, // Up out
  input wire logic downOut, // Down out
  input wire ptc_pkg::ptc_count_t upCount, // Up count
  input wire ptc_pkg::ptc_count_t downCount // Down count
);
  ptc_pkg::ptc_inputs_t sIn, pIn;
  ptc_pkg::ptc_count_t oUp, oDn;
  logic ue, ce, de, le, pe;
  // This tick's sample, previous tick's sample and counts
  always_ff @(posedge ref_clk) begin
    sIn <= sheetIn;
    if (rst) begin
      pIn <= '0;
      oUp <= '0;
      oDn <= '0;
    end else if (tick) begin
      pIn <= sIn;
      oUp <= upCount;
      oDn <= downCount;
    end
  end
  // Edges seen on the current tick
  assign ue = sIn.countUpInput & ~pIn.countUpInput;
  assign ce = sIn.upClear & ~pIn.upClear;
  assign de = sIn.countDownInput & ~pIn.countDownInput;
  assign le = sIn.loadInput & ~pIn.loadInput;
  assign pe = sIn.pulseIn & ~pIn.pulseIn;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_pulse_edge; tick && pe; endsequence
  property p_pulse; s_pulse_edge |-> pulseOut == (presetDuration != '0); endproperty
  a_pulse: assert property (p_pulse) else $error("pulse start wrong");
  property p_up_inc; tick && ue && !ce |-> upCount == ((oUp < upPreset) ? oUp + 1'b1 : oUp);
  endproperty
  a_up_inc: assert property (p_up_inc) else $error("up step wrong");
  property p_up_out; tick |-> upOut == (upCount >= upPreset); endproperty
  a_up_out: assert property (p_up_out) else $error("up out wrong");
  property p_clear; tick && ce |-> upCount == '0; endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");
  property p_load; tick && le |-> downCount == downPreset; endproperty
  a_load: assert property (p_load) else $error("load wrong");
  property p_dn_dec; tick && de && !le |-> downCount == ((oDn != '0) ? oDn - 1'b1 : oDn);
  endproperty
  a_dn_dec: assert property (p_dn_dec) else $error("down step wrong");
  property p_dn_out; tick |-> downOut == (downCount == '0); endproperty
  a_dn_out: assert property (p_dn_out) else $error("down out wrong");
  property p_hold; !tick |-> $stable(upCount) && $stable(downCount) && $stable(pulseOut);
  endproperty
  a_hold: assert property (p_hold) else $error("change off tick");
  property p_reset;
    disable iff (1'b0) rst |=> !pulseOut && upCount == '0 && downCount == '0 && downOut;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
bind ptc_pulse_timer_counters ptc_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .sheetIn(sheetIn), .presetDuration(presetDuration),
  .upPreset(upPreset), .downPreset(downPreset), .tick(tick), .pulseOut(pulseOut),
  .upOut(upOut), .downOut(downOut), .upCount(upCount), .downCount(downCount));

// ### ptc_sheet_src.sv
// Purpose: Stand-in for sheet gates feeding the primitives
// Assumes: One clock of gate delay
// Notes: Registered like a gate output
`timescale 1ns/1ps
module ptc_sheet_src (
  input wire logic ref_clk, // Clock
  input wire ptc_pkg::ptc_inputs_t req, // Levels asked for
  output ptc_pkg::ptc_inputs_t sheetIn // Levels seen by primitives
);
  // Gate output moves once per clock
  always_ff @(posedge ref_clk) begin
    sheetIn <= req;
  end
endmodule

// ### ptc_testbench.sv
// Purpose: Self-checking bench for pulse timer and counters
// Assumes: Four clocks per tick; presets 3, 2 and 2, then 0, 0 and 5 after reset
// Notes: One row per tick: inputs, up, down, pulse
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, tick, pulseOut, upOut, downOut;
  ptc_pkg::ptc_inputs_t req, sheetIn;
  ptc_pkg::ptc_count_t upCount, downCount;
  ptc_pkg::ptc_time_t presetDur;
  ptc_pkg::ptc_count_t upPre, downPre;
  int mismatches, checks_done, cyc, i;
  logic [9:0] rows [13] = '{10'h12c, 10'h04a, 10'h313, 10'h075, 10'h255, 10'h185,
    10'h143, 10'h002, 10'h148, 10'h008, 10'h150, 10'h010, 10'h110};
  ptc_sheet_src src_u (.ref_clk(ref_clk), .req(req), .sheetIn(sheetIn));
  ptc_pulse_timer_counters #(.TICK_CYCLES(4)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .sheetIn(sheetIn), .presetDuration(presetDur), .upPreset(upPre),
    .downPreset(downPre), .tick(tick), .pulseOut(pulseOut), .upOut(upOut),
    .downOut(downOut), .upCount(upCount), .downCount(downCount));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_tick;
    do begin
      @(posedge ref_clk);
      #1;
    end while (tick !== 1'b1);
  endtask
  task wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      wrap_up;
    end
  end
  // Row loop, then mid-run reset
  initial begin
    mismatches = 0;
    checks_done = 0;
    cyc = 0;
    rst = 1'b1;
    req = '0;
    presetDur = 16'h0003;
    upPre = 16'h0002;
    downPre = 16'h0002;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 13; i++) begin
      @(posedge ref_clk) req <= rows[i][9:5];
      wait_tick;
      chk("upCount", upCount, {14'h0000, rows[i][4:3]});
      chk("downCount", downCount, {14'h0000, rows[i][2:1]});
      chk("pulseOut", {15'h0000, pulseOut}, {15'h0000, rows[i][0]});
      chk("upOut", {15'h0000, upOut}, {15'h0000, rows[i][4]});
      chk("downOut", {15'h0000, downOut}, {15'h0000, rows[i][2:1] == 2'h0});
    end
    // Mid-run reset with new presets: zero length, zero up preset, load 5
    @(posedge ref_clk) begin
      rst <= 1'b1;
      req <= '0;
      presetDur <= 16'h0000;
      upPre <= 16'h0000;
      downPre <= 16'h0005;
    end
    repeat (20) @(posedge ref_clk);
    #1;
    chk("rstUp", upCount, 16'h0000);
    chk("rstDown", downCount, 16'h0000);
    chk("rstTick", {15'h0000, tick}, 16'h0000);
    chk("rstOut", {13'h0000, pulseOut, upOut, downOut}, 16'h0001);
    // Release; pulse, count-up and load all rise on the first tick
    @(posedge ref_clk) begin
      rst <= 1'b0;
      req <= 5'h19;
    end
    for (i = 1; i < 4; i++) begin
      @(posedge ref_clk);
      #1;
      chk("relTick", {15'h0000, tick}, 16'h0000);
      chk("relUpOut", {15'h0000, upOut}, 16'h0001);
    end
    @(posedge ref_clk);
    #1;
    chk("relTick", {15'h0000, tick}, 16'h0001);
    chk("zeroPulse", {15'h0000, pulseOut}, 16'h0000);
    chk("upAtZero", upCount, 16'h0000);
    chk("upOutAtZero", {15'h0000, upOut}, 16'h0001);
    chk("loadFive", downCount, 16'h0005);
    chk("downOutLoaded", {15'h0000, downOut}, 16'h0000);
    wrap_up;
  end
endmodule
